// ### hdl/cbc_pkg.sv
/*
 * Shared constants and types for the processor bus control pins and the
 * external memory / DMA master end.
 * Assumes a single 100 MHz clock on both ends.
 */
package cbc_pkg;
   // ------------------------------------------------------------
   // Widths and counts
   // ------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int COND_W = 4;
   localparam int IRQ_W = 6;
   localparam int BURST_WORDS = 4;
   localparam logic [1:0] WORD_CNT_ZERO = 2'h0;
   localparam logic [1:0] WORD_CNT_LAST = 2'h3;
   // Positions of the two interrupt groups in the six-line word
   localparam int IRQ_SYNC_LO = 0;
   localparam int IRQ_SYNC_HI = 2;
   localparam int IRQ_DIR_LO = 3;
   localparam int IRQ_DIR_HI = 5;
   // Positions of the two branch flag groups
   localparam int BR_DIR_HI = 1;
   localparam int BR_SYNC_LO = 2;
   localparam int BR_SYNC_HI = 3;
   // Reset values
   localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;
   localparam logic [COND_W-1:0] COND_RESET = 4'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

   // Bus interface states of the processor end
   typedef enum logic [2:0] {
      CBC_IDLE,
      CBC_READ,
      CBC_WRITE,
      CBC_GRANTED
   } cbc_bus_state_t;

   // Memory end states
   typedef enum logic [1:0] {
      CBC_MEM_IDLE,
      CBC_MEM_WAIT,
      CBC_MEM_DATA
   } cbc_mem_state_t;
endpackage : cbc_pkg

// ### hdl/cbc_if.sv
/*
 * Pins between the processor end and the memory / DMA master end.
 * Assumes both ends run on ref_clk_i; bus outputs carry an enable.
 */
`timescale 1ns/10ps
interface cbc_if;
   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   logic system_reference_clock_out;
   logic read_strobe;
   logic write_strobe;
   logic block_fetch;
   logic bus_out_en;
   logic [cbc_pkg::DATA_W-1:0] wdata;
   logic ack;
   logic read_buffer_capture_enable;
   logic [cbc_pkg::DATA_W-1:0] rdata;
   logic external_master_request;
   logic external_master_grant;
   logic bus_fault_input;
   logic [cbc_pkg::BR_SYNC_HI:cbc_pkg::BR_SYNC_LO] branch_flag_synced;
   logic [cbc_pkg::BR_DIR_HI:0] branch_flag_direct;
   logic [cbc_pkg::IRQ_SYNC_HI:cbc_pkg::IRQ_SYNC_LO] irq_synced;
   logic [cbc_pkg::IRQ_DIR_HI:cbc_pkg::IRQ_DIR_LO] irq_direct;

   // Processor side
   modport cpu (
      output system_reference_clock_out, read_strobe, write_strobe,
      output block_fetch, bus_out_en, wdata, external_master_grant,
      input ack, read_buffer_capture_enable, rdata,
      input external_master_request, bus_fault_input,
      input branch_flag_synced, branch_flag_direct, irq_synced, irq_direct
   );

   // Memory system and external master side
   modport mem (
      input system_reference_clock_out, read_strobe, write_strobe,
      input block_fetch, bus_out_en, wdata, external_master_grant,
      output ack, read_buffer_capture_enable, rdata,
      output external_master_request, bus_fault_input,
      output branch_flag_synced, branch_flag_direct, irq_synced, irq_direct
   );
endinterface : cbc_if

// ### hdl/cbc_sync2.sv
/*
 * Two-flop synchroniser, parameterised width.
 * Assumes the input is asynchronous to ref_clk_i.
 */
`timescale 1ns/10ps
module cbc_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Data
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_reg;
   logic [W-1:0] sync_next;

   // Next values: first stage only feeds the second
   always_comb begin
      meta_next = async_i;
      sync_next = meta_reg;
   end

   // Register both stages
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg;
endmodule : cbc_sync2

// ### hdl/cbc_cpu.sv
/*
 * Processor end of the bus control pins: transfer sequencing with
 * acknowledge, read buffer capture and bus fault, DMA grant, branch
 * condition and interrupt inputs, mode capture at reset release.
 * Assumes the far end drives direct inputs synchronously to ref_clk_i.
 */
// What this block does
// (R1) Acknowledge ends write or consumes read
// (R2) Capture enable latches bus word into buffer
// (R3) Reference clock output sequences bus machines
// (R4) All timing from double-rate master clock
// (R5) Request makes processor release bus outputs
// (R6) Grant output signals bus released
// (R7) Four branch flags drive coprocessor condition lines
// (R8) Branch flags 3:2 synchronised internally
// (R9) Branch flags 1:0 driven synchronously externally
// (R10) Bus fault ends transfer, sampled only in transfer
// (R11) Bus fault on read raises exception
// (R12) Six interrupt lines form one request word
// (R13) Interrupt pins sampled as modes at reset end
// (R14) Synced interrupts pass internal synchronisers
// (R15) Direct interrupts synchronised by external logic
// (R16) Direct interrupts seen one cycle sooner
// (R17) Separate read and write indicator outputs
// (R18) Block fetch requests four words
// (R19) Grant held until request withdrawn
`timescale 1ns/10ps
module cbc_cpu (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Pins
   cbc_if.cpu bus,
   // Core requests
   input wire logic rd_req_i,
   input wire logic wr_req_i,
   input wire logic miss_i,
   input wire logic [cbc_pkg::DATA_W-1:0] wdata_i,
   // Core results
   output logic busy_o,
   output logic done_o,
   output logic [cbc_pkg::DATA_W-1:0] rdata_o,
   output logic rvalid_o,
   output logic bus_fault_exc_o,
   output logic [cbc_pkg::COND_W-1:0] coproc_condition_lines_o,
   output logic [cbc_pkg::IRQ_W-1:0] irq_lines_o,
   output logic [cbc_pkg::IRQ_W-1:0] mode_o
);
   // ------------------------------------------------------------
   // Reference clock
   // ------------------------------------------------------------
   // The master clock is ref_clk_i; the system clock is every other
   // edge, made as a toggle that also serves as the pin output.
   logic sys_clk_reg, sys_clk_next;
   logic sys_en;

   // Half-rate divider
   always_comb begin
      sys_clk_next = ~sys_clk_reg; // R4
   end
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sys_clk_reg <= 1'b0;
      end else begin
         sys_clk_reg <= sys_clk_next;
      end
   end
   assign sys_en = sys_clk_reg; // R3
   assign bus.system_reference_clock_out = sys_clk_reg; // R3

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [cbc_pkg::BR_SYNC_HI:cbc_pkg::BR_SYNC_LO] br_s;
   logic [cbc_pkg::IRQ_SYNC_HI:cbc_pkg::IRQ_SYNC_LO] irq_s;

   cbc_sync2 #(.W(2)) u_br_sync (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .async_i(bus.branch_flag_synced), // R8
      .sync_o(br_s)
   );
   cbc_sync2 #(.W(3)) u_irq_sync (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .async_i(bus.irq_synced), // R14
      .sync_o(irq_s)
   );

   // ------------------------------------------------------------
   // Condition, interrupt and mode registers
   // ------------------------------------------------------------
   logic [cbc_pkg::COND_W-1:0] cond_reg, cond_next;
   logic [cbc_pkg::IRQ_DIR_HI:cbc_pkg::IRQ_DIR_LO] irq_reg, irq_next;
   logic [cbc_pkg::IRQ_W-1:0] mode_reg, mode_next;
   logic mode_done_reg, mode_done_next;

   // Direct interrupts take one flop, synced ones two: one cycle sooner
   always_comb begin
      cond_next = {br_s, bus.branch_flag_direct}; // R7 R9
      irq_next = bus.irq_direct; // R15 R16
      mode_next = mode_reg;
      mode_done_next = 1'b1;
      if (!mode_done_reg) begin
         mode_next = {bus.irq_direct, bus.irq_synced}; // R13
      end
   end
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cond_reg <= cbc_pkg::COND_RESET;
         irq_reg <= cbc_pkg::IRQ_RESET[cbc_pkg::IRQ_DIR_HI:
                                       cbc_pkg::IRQ_DIR_LO];
         mode_reg <= cbc_pkg::IRQ_RESET;
         mode_done_reg <= 1'b0;
      end else begin
         cond_reg <= cond_next;
         irq_reg <= irq_next;
         mode_reg <= mode_next;
         mode_done_reg <= mode_done_next;
      end
   end
   assign coproc_condition_lines_o = cond_reg;
   assign irq_lines_o = {irq_reg, irq_s}; // R12 R16
   assign mode_o = mode_reg;

   // ------------------------------------------------------------
   // Bus interface state machine
   // ------------------------------------------------------------
   cbc_pkg::cbc_bus_state_t st_reg, st_next;
   logic rd_reg, rd_next;
   logic wr_reg, wr_next;
   logic blk_reg, blk_next;
   logic oe_reg, oe_next;
   logic gnt_reg, gnt_next;
   logic done_reg, done_next;
   logic rv_reg, rv_next;
   logic exc_reg, exc_next;
   logic busy_reg, busy_next;
   logic [1:0] cnt_reg, cnt_next;
   logic [cbc_pkg::DATA_W-1:0] wd_reg, wd_next;
   logic [cbc_pkg::DATA_W-1:0] rd_buf_reg, rd_buf_next;

   // Transfer sequencing, advancing on system clock enable only
   always_comb begin
      st_next = st_reg;
      rd_next = rd_reg;
      wr_next = wr_reg;
      blk_next = blk_reg;
      oe_next = oe_reg;
      gnt_next = gnt_reg;
      done_next = 1'b0;
      rv_next = 1'b0;
      exc_next = 1'b0;
      cnt_next = cnt_reg;
      wd_next = wd_reg;
      rd_buf_next = rd_buf_reg;
      if (sys_en) begin
         unique case (st_reg)
            cbc_pkg::CBC_IDLE: begin
               if (bus.external_master_request) begin
                  st_next = cbc_pkg::CBC_GRANTED;
                  oe_next = 1'b0; // R5
                  gnt_next = 1'b1; // R6
               end else if (rd_req_i) begin
                  st_next = cbc_pkg::CBC_READ;
                  rd_next = 1'b1; // R17
                  blk_next = miss_i; // R18
                  cnt_next = cbc_pkg::WORD_CNT_ZERO;
               end else if (wr_req_i) begin
                  st_next = cbc_pkg::CBC_WRITE;
                  wr_next = 1'b1; // R17
                  wd_next = wdata_i;
               end
            end
            cbc_pkg::CBC_READ: begin
               if (bus.bus_fault_input) begin // R10
                  exc_next = 1'b1; // R11
                  done_next = 1'b1;
                  rd_next = 1'b0;
                  blk_next = 1'b0;
                  st_next = cbc_pkg::CBC_IDLE;
               end else if (bus.read_buffer_capture_enable) begin
                  rd_buf_next = bus.rdata; // R2
                  rv_next = 1'b1;
                  if (!blk_reg || cnt_reg == cbc_pkg::WORD_CNT_LAST ||
                      bus.ack) begin // R1 R18
                     done_next = 1'b1;
                     rd_next = 1'b0;
                     blk_next = 1'b0;
                     st_next = cbc_pkg::CBC_IDLE;
                  end
                  cnt_next = cnt_reg + 2'h1;
               end
            end
            cbc_pkg::CBC_WRITE: begin
               if (bus.ack || bus.bus_fault_input) begin // R1 R10
                  done_next = 1'b1;
                  wr_next = 1'b0;
                  st_next = cbc_pkg::CBC_IDLE;
               end
            end
            cbc_pkg::CBC_GRANTED: begin
               if (!bus.external_master_request) begin // R19
                  gnt_next = 1'b0;
                  oe_next = 1'b1;
                  st_next = cbc_pkg::CBC_IDLE;
               end
            end
            default: begin
               st_next = cbc_pkg::CBC_IDLE;
            end
         endcase
      end
      busy_next = rd_next | wr_next | gnt_next;
   end
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= cbc_pkg::CBC_IDLE;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         blk_reg <= 1'b0;
         oe_reg <= 1'b1;
         gnt_reg <= 1'b0;
         done_reg <= 1'b0;
         rv_reg <= 1'b0;
         exc_reg <= 1'b0;
         busy_reg <= 1'b0;
         cnt_reg <= cbc_pkg::WORD_CNT_ZERO;
         wd_reg <= cbc_pkg::DATA_RESET;
         rd_buf_reg <= cbc_pkg::DATA_RESET;
      end else begin
         st_reg <= st_next;
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         blk_reg <= blk_next;
         oe_reg <= oe_next;
         gnt_reg <= gnt_next;
         done_reg <= done_next;
         rv_reg <= rv_next;
         exc_reg <= exc_next;
         busy_reg <= busy_next;
         cnt_reg <= cnt_next;
         wd_reg <= wd_next;
         rd_buf_reg <= rd_buf_next;
      end
   end

   // Pin and core outputs, all from flops
   assign bus.read_strobe = rd_reg;
   assign bus.write_strobe = wr_reg;
   assign bus.block_fetch = blk_reg;
   assign bus.bus_out_en = oe_reg; // R5
   assign bus.wdata = wd_reg;
   assign bus.external_master_grant = gnt_reg; // R6
   assign busy_o = busy_reg;
   assign done_o = done_reg;
   assign rvalid_o = rv_reg;
   assign rdata_o = rd_buf_reg;
   assign bus_fault_exc_o = exc_reg;
endmodule : cbc_cpu

// ### hdl/cbc_mem.sv
/*
 * Memory system and DMA master end: answers reads with capture enable,
 * single reads also with acknowledge, accepts writes, requests the bus.
 * Assumes cbc_cpu on the other side of cbc_if, same clock.
 */
`timescale 1ns/10ps
module cbc_mem (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Pins
   cbc_if.mem bus,
   // User controls
   input wire logic dma_req_i,
   input wire logic fault_i,
   input wire logic [cbc_pkg::DATA_W-1:0] rdata_i,
   input wire logic [cbc_pkg::COND_W-1:0] cond_i,
   input wire logic [cbc_pkg::IRQ_W-1:0] irq_i,
   // User status
   output logic dma_owner_o,
   output logic wr_seen_o,
   output logic [cbc_pkg::DATA_W-1:0] wdata_o
);
   cbc_pkg::cbc_mem_state_t st_reg, st_next;
   logic cap_reg, cap_next;
   logic ack_reg, ack_next;
   logic req_reg, req_next;
   logic flt_reg, flt_next;
   logic ws_reg, ws_next;
   logic [cbc_pkg::DATA_W-1:0] rd_reg, rd_next;
   logic [cbc_pkg::DATA_W-1:0] wd_reg, wd_next;
   logic [cbc_pkg::COND_W-1:0] cnd_reg, cnd_next;
   logic [cbc_pkg::IRQ_W-1:0] irq_reg, irq_next;
   logic sys_q_reg;
   logic sys_en;

   // ------------------------------------------------------------
   // Responder
   // ------------------------------------------------------------
   // Acts on the cycle before the processor samples (reference clock low)
   assign sys_en = ~bus.system_reference_clock_out;

   always_comb begin
      st_next = st_reg;
      cap_next = cap_reg;
      ack_next = ack_reg;
      req_next = dma_req_i; // R19
      flt_next = flt_reg;
      ws_next = 1'b0;
      rd_next = rd_reg;
      wd_next = wd_reg;
      cnd_next = cond_i; // R9
      irq_next = irq_i; // R15
      if (sys_en) begin
         cap_next = 1'b0;
         ack_next = 1'b0;
         flt_next = 1'b0;
         unique case (st_reg)
            cbc_pkg::CBC_MEM_IDLE: begin
               if (bus.read_strobe) begin
                  st_next = cbc_pkg::CBC_MEM_DATA;
                  rd_next = rdata_i;
                  cap_next = ~fault_i; // R2
                  flt_next = fault_i; // R10
                  ack_next = ~fault_i & ~bus.block_fetch; // R1
               end else if (bus.write_strobe) begin
                  st_next = cbc_pkg::CBC_MEM_WAIT;
                  ack_next = ~fault_i; // R1
                  flt_next = fault_i;
                  wd_next = bus.wdata;
                  ws_next = 1'b1;
               end
            end
            cbc_pkg::CBC_MEM_DATA: begin
               if (bus.read_strobe) begin
                  cap_next = 1'b1; // R18
                  rd_next = rd_reg + 32'h0000_0001;
               end else begin
                  st_next = cbc_pkg::CBC_MEM_IDLE;
               end
            end
            cbc_pkg::CBC_MEM_WAIT: begin
               if (!bus.write_strobe) begin
                  st_next = cbc_pkg::CBC_MEM_IDLE;
               end
            end
            default: begin
               st_next = cbc_pkg::CBC_MEM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= cbc_pkg::CBC_MEM_IDLE;
         cap_reg <= 1'b0;
         ack_reg <= 1'b0;
         req_reg <= 1'b0;
         flt_reg <= 1'b0;
         ws_reg <= 1'b0;
         rd_reg <= cbc_pkg::DATA_RESET;
         wd_reg <= cbc_pkg::DATA_RESET;
         sys_q_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cap_reg <= cap_next;
         ack_reg <= ack_next;
         req_reg <= req_next;
         flt_reg <= flt_next;
         ws_reg <= ws_next;
         rd_reg <= rd_next;
         wd_reg <= wd_next;
         sys_q_reg <= bus.external_master_grant;
      end
   end

   // Pin values follow the user through reset, so modes stand at release
   always_ff @(posedge ref_clk_i) begin
      cnd_reg <= cnd_next;
      irq_reg <= irq_next; // R13
   end

   // Pin drives, all from flops
   assign bus.read_buffer_capture_enable = cap_reg;
   assign bus.ack = ack_reg;
   assign bus.rdata = rd_reg;
   assign bus.external_master_request = req_reg; // R5
   assign bus.bus_fault_input = flt_reg;
   assign bus.branch_flag_synced = cnd_reg[cbc_pkg::BR_SYNC_HI:
                                           cbc_pkg::BR_SYNC_LO];
   assign bus.branch_flag_direct = cnd_reg[cbc_pkg::BR_DIR_HI:0];
   assign bus.irq_synced = irq_reg[cbc_pkg::IRQ_SYNC_HI:
                                   cbc_pkg::IRQ_SYNC_LO];
   assign bus.irq_direct = irq_reg[cbc_pkg::IRQ_DIR_HI:
                                   cbc_pkg::IRQ_DIR_LO];
   assign dma_owner_o = sys_q_reg;
   assign wr_seen_o = ws_reg;
   assign wdata_o = wd_reg;
endmodule : cbc_mem

// ### testbench/cbc_asserts.sv
/*
 * Checker on the pins between the processor end and the memory end.
 * Assumes one clock, an async active-low reset, and the pin signals of
 * cbc_if wired in by name from the testbench.
 */
`timescale 1ns/10ps
module cbc_asserts (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Pins
   input wire logic system_reference_clock_out,
   input wire logic read_strobe,
   input wire logic write_strobe,
   input wire logic block_fetch,
   input wire logic bus_out_en,
   input wire logic ack,
   input wire logic bus_fault_input,
   input wire logic external_master_request,
   input wire logic external_master_grant
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // ------------------------------------------------------------
   // Pin relations
   // ------------------------------------------------------------
   property p_ref_toggle;
      $past(nrst_i) |-> system_reference_clock_out !=
         $past(system_reference_clock_out);
   endproperty
   a_ref_toggle: assert property (p_ref_toggle) else $error("ref clk");
   property p_rd_wr_excl;
      !(read_strobe && write_strobe);
   endproperty
   a_rd_wr_excl: assert property (p_rd_wr_excl) else $error("rd wr");
   property p_burst_read;
      block_fetch |-> read_strobe;
   endproperty
   a_burst_read: assert property (p_burst_read) else $error("burst");
   property p_write_hold;
      write_strobe && !ack && !bus_fault_input |=> write_strobe;
   endproperty
   a_write_hold: assert property (p_write_hold) else $error("write");
   property p_fault_end;
      bus_fault_input && (read_strobe || write_strobe) |->
         ##[1:3] !(read_strobe || write_strobe);
   endproperty
   a_fault_end: assert property (p_fault_end) else $error("fault");
   property p_grant_follow;
      $rose(external_master_request) |-> ##[1:4] external_master_grant;
   endproperty
   a_grant_follow: assert property (p_grant_follow) else $error("gnt");
   property p_grant_hold;
      external_master_grant && external_master_request |=>
         external_master_grant;
   endproperty
   a_grant_hold: assert property (p_grant_hold) else $error("hold");
   property p_grant_quiet;
      external_master_grant |-> !bus_out_en && !read_strobe && !write_strobe;
   endproperty
   a_grant_quiet: assert property (p_grant_quiet) else $error("quiet");
endmodule : cbc_asserts

// ### testbench/tb.sv
/*
 * Testbench: processor end and memory end joined by cbc_if.
 * Assumes the design files under hdl/ are compiled first.
 */
`timescale 1ns/10ps
module tb;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic rd_req_i = 1'b0, wr_req_i = 1'b0, miss_i = 1'b0;
   logic [31:0] wdata_i = 32'h0000_0000, rdata_o, rdata_i = 32'h0000_0000;
   logic busy_o, done_o, rvalid_o, bus_fault_exc_o, dma_owner_o, wr_seen_o;
   logic [3:0] coproc_condition_lines_o, cond_i = 4'h0;
   logic [5:0] irq_lines_o, mode_o, irq_i = 6'h00;
   logic dma_req_i = 1'b0, fault_i = 1'b0;
   logic [31:0] wdata_o;
   int num_errors = 0;
   int cmp_count = 0;
   // ------------------------------------------------------------
   // Clock, ends and checker
   // ------------------------------------------------------------
   always #5 ref_clk_i = ~ref_clk_i;
   cbc_if u_cbc_if ();
   cbc_cpu u_cbc_cpu (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus(u_cbc_if),
      .rd_req_i(rd_req_i), .wr_req_i(wr_req_i), .miss_i(miss_i),
      .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
      .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .bus_fault_exc_o(bus_fault_exc_o),
      .coproc_condition_lines_o(coproc_condition_lines_o),
      .irq_lines_o(irq_lines_o), .mode_o(mode_o));
   cbc_mem u_cbc_mem (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus(u_cbc_if),
      .dma_req_i(dma_req_i), .fault_i(fault_i), .rdata_i(rdata_i),
      .cond_i(cond_i), .irq_i(irq_i), .dma_owner_o(dma_owner_o),
      .wr_seen_o(wr_seen_o), .wdata_o(wdata_o));
   cbc_asserts u_cbc_asserts (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .system_reference_clock_out(u_cbc_if.system_reference_clock_out),
      .read_strobe(u_cbc_if.read_strobe),
      .write_strobe(u_cbc_if.write_strobe),
      .block_fetch(u_cbc_if.block_fetch), .bus_out_en(u_cbc_if.bus_out_en),
      .ack(u_cbc_if.ack), .bus_fault_input(u_cbc_if.bus_fault_input),
      .external_master_request(u_cbc_if.external_master_request),
      .external_master_grant(u_cbc_if.external_master_grant));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Compare and count
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   // One core transfer; request held until done, words counted
   task automatic xfer(input logic wr, input logic blk, output int words,
      output logic [31:0] last, output logic exc);
      logic fin;
      words = 0;
      exc = 1'b0;
      fin = 1'b0;
      last = 32'h0000_0000;
      @(posedge ref_clk_i);
      rd_req_i <= !wr;
      wr_req_i <= wr;
      miss_i <= blk;
      for (int n = 0; n < 80 && !fin; n++) begin
         @(posedge ref_clk_i);
         #1;
         if (rvalid_o === 1'b1 || wr_seen_o === 1'b1) begin
            words++;
            last = rdata_o;
         end
         exc |= (bus_fault_exc_o === 1'b1);
         fin = (done_o === 1'b1) || exc;
      end
      check("transfer end", fin, 1'b1);
      @(posedge ref_clk_i);
      rd_req_i <= 1'b0;
      wr_req_i <= 1'b0;
      miss_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      exc |= (bus_fault_exc_o === 1'b1);
   endtask : xfer
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset with mode values on the interrupt pins
   task automatic test_mode(input logic [5:0] m);
      @(posedge ref_clk_i);
      nrst_i <= 1'b0;
      irq_i <= m;
      repeat (10) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      irq_i <= 6'h00;
      repeat (3) @(posedge ref_clk_i);
      check("mode", mode_o, m);
      $display("test mode done");
   endtask : test_mode
   // Single and burst reads, a write, faulted read and write, then a clean read
   task automatic test_xfers;
      int w;
      logic [31:0] d;
      logic e;
      rdata_i <= 32'h1234_5670;
      xfer(1'b0, 1'b0, w, d, e);
      check("single words", w, 1);
      check("single data", d, 32'h1234_5670);
      xfer(1'b0, 1'b1, w, d, e);
      check("burst words", w, 4);
      check("burst last", d, 32'h1234_5673);
      wdata_i <= 32'hCAFE_0001;
      xfer(1'b1, 1'b0, w, d, e);
      check("write data", wdata_o, 32'hCAFE_0001);
      check("write words", w, 1);
      fault_i <= 1'b1;
      xfer(1'b0, 1'b0, w, d, e);
      check("read fault exc", e, 1'b1);
      xfer(1'b1, 1'b0, w, d, e);
      check("write fault exc", e, 1'b0);
      fault_i <= 1'b0;
      xfer(1'b0, 1'b0, w, d, e);
      check("after fault exc", e, 1'b0);
      $display("test transfers done");
   endtask : test_xfers
   // External master takes and returns the bus
   task automatic test_dma;
      logic seen;
      seen = 1'b0;
      dma_req_i <= 1'b1;
      for (int n = 0; n < 20 && dma_owner_o !== 1'b1; n++) @(posedge ref_clk_i);
      check("grant", u_cbc_if.external_master_grant, 1'b1);
      check("bus released", u_cbc_if.bus_out_en, 1'b0);
      check("busy granted", busy_o, 1'b1);
      rd_req_i <= 1'b1;
      repeat (10) begin
         @(posedge ref_clk_i);
         seen |= (u_cbc_if.read_strobe !== 1'b0);
      end
      check("strobe while granted", seen, 1'b0);
      rd_req_i <= 1'b0;
      @(posedge ref_clk_i);
      dma_req_i <= 1'b0;
      for (int n = 0; n < 20 && dma_owner_o !== 1'b0; n++) @(posedge ref_clk_i);
      repeat (2) @(posedge ref_clk_i);
      check("grant drop", u_cbc_if.external_master_grant, 1'b0);
      check("bus back", u_cbc_if.bus_out_en, 1'b1);
      check("busy after", busy_o, 1'b0);
      $display("test dma done");
   endtask : test_dma
   // Interrupt latency and branch flags
   task automatic test_inputs;
      int t_dir, t_syn;
      t_dir = -1;
      t_syn = -1;
      @(posedge ref_clk_i);
      irq_i <= 6'h3F;
      for (int n = 0; n < 12; n++) begin
         @(posedge ref_clk_i);
         #1;
         if (t_dir < 0 && irq_lines_o[3] === 1'b1) t_dir = n;
         if (t_syn < 0 && irq_lines_o[0] === 1'b1) t_syn = n;
      end
      check("irq lead", t_syn - t_dir, 1);
      check("irq lines", irq_lines_o, 6'h3F);
      @(posedge ref_clk_i);
      irq_i <= 6'h00;
      cond_i <= 4'hA;
      repeat (8) @(posedge ref_clk_i);
      check("cond A", coproc_condition_lines_o, 4'hA);
      cond_i <= 4'h5;
      repeat (8) @(posedge ref_clk_i);
      check("cond 5", coproc_condition_lines_o, 4'h5);
      $display("test inputs done");
   endtask : test_inputs
   // Counts, verdict and end of run
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      test_mode(6'h2D);
      test_xfers;
      test_dma;
      test_inputs;
      test_mode(6'h12);
      test_xfers;
      give_verdict;
   end
   initial begin
      #100000;
      num_errors++;
      give_verdict;
   end
endmodule : tb
